/* shared/sysref_regs.vh */
// register map, field positions and reset values of the sysref capture monitor
`ifndef SYSREF_REGS_VH
`define SYSREF_REGS_VH

`define ADDR_SYSREF_CONTROL      12'h120
`define ADDR_SYSREF_IGNORE_COUNT 12'h121
`define ADDR_SYSREF_TS_DELAY     12'h123
`define ADDR_SYSREF_SETUP_HOLD   12'h128
`define ADDR_SYSREF_DIV_PHASE    12'h129
`define ADDR_SYSREF_EVENT_COUNT  12'h12a

`define CTRL_FLAG_RESET_BIT      6
`define CTRL_TRANS_SEL_BIT       4
`define CTRL_EDGE_SEL_BIT        3
`define CTRL_MODE_HI             2
`define CTRL_MODE_LO             1

`define MODE_DISABLED            2'h0
`define MODE_CONTINUOUS          2'h1
`define MODE_NSHOT               2'h2

`define RST_CONTROL              8'h00
`define RST_IGNORE_COUNT         4'h0
`define RST_TS_DELAY             7'h40
`define RST_STATUS               8'h00

`define HOLD_WINDOW_CYCLES       3'h4

`endif

/* logic/sysref_window_monitor.v */
// setup and hold stability monitor around each captured sysref transition
`timescale 1ns/1ps
`include "sysref_regs.vh"

module sysref_window_monitor (
    input  wire       clock,
    input  wire       sys_rst,
    input  wire       flagReset,
    input  wire       level,
    input  wire       capture,
    output wire [3:0] setupStatus,
    output wire [3:0] holdStatus
);
    reg [4:0] history_q;
    reg [3:0] setup_q;
    reg [3:0] hold_q;
    reg [2:0] holdWait_q;
    reg       postLevel_q;

    assign setupStatus = setup_q;
    assign holdStatus  = hold_q;

    always @(posedge clock) begin
        if (sys_rst) begin
            history_q   <= 5'h00;
            setup_q     <= 4'h0;
            hold_q      <= 4'h0;
            holdWait_q  <= 3'h0;
            postLevel_q <= 1'b0;
        end else begin
            history_q <= {history_q[3:0], level};
            if (flagReset) begin
                // flags held cleared while the flag reset is set
                setup_q    <= 4'h0;
                hold_q     <= 4'h0;
                holdWait_q <= 3'h0;
            end else if (capture) begin
                // bit i set: level was still at its old value i+2 cycles before
                setup_q     <= ~(history_q[4:1] ^ {4{history_q[0]}});
                postLevel_q <= level;
                holdWait_q  <= `HOLD_WINDOW_CYCLES;
            end else if (holdWait_q != 3'h0) begin
                holdWait_q <= holdWait_q - 3'h1;
                if (holdWait_q == 3'h1) begin
                    // bit i set: new level still held 3-i cycles after capture
                    hold_q <= ~(history_q[3:0] ^ {4{postLevel_q}});
                end
            end
        end
    end
endmodule

/* logic/sysref_capture_monitor.v */
// sysref capture, n-shot skip, timestamp delay and status registers
`timescale 1ns/1ps
`include "sysref_regs.vh"

module sysref_capture_monitor (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire        sysrefIn,
    input  wire [11:0] address,
    input  wire [7:0]  writeData,
    input  wire        writeStrobe,
    input  wire        readStrobe,
    output reg  [7:0]  readData,
    output reg         captureStrobe,
    output reg         timestampStrobe
);
    localparam [2:0] ST_IDLE  = 3'b001;
    localparam [2:0] ST_ARMED = 3'b010;
    localparam [2:0] ST_DONE  = 3'b100;

    reg [7:0]   control_q;
    reg [3:0]   ignoreCount_q;
    reg [6:0]   tsDelay_q;
    reg [3:0]   divPhase_q;
    reg [7:0]   eventCount_q;
    reg [2:0]   state_q;
    reg [3:0]   skipLeft_q;
    reg [2:0]   divider_q;
    reg         negSync1_q;
    reg         negSync2_q;
    reg         sync1_q;
    reg         sync2_q;
    reg         level_q;
    reg [126:0] delayLine_q;

    wire       flagReset  = control_q[`CTRL_FLAG_RESET_BIT];
    wire       transSel   = control_q[`CTRL_TRANS_SEL_BIT];
    wire       edgeSel    = control_q[`CTRL_EDGE_SEL_BIT];
    wire [1:0] mode       = control_q[`CTRL_MODE_HI:`CTRL_MODE_LO];
    wire       ctrlWrite  = writeStrobe && (address == `ADDR_SYSREF_CONTROL);
    wire [1:0] newMode    = writeData[`CTRL_MODE_HI:`CTRL_MODE_LO];
    // both sampling paths are fully synchronised before this mux
    wire       pinLevel   = edgeSel ? negSync2_q : sync2_q;
    wire       riseSeen   = pinLevel & ~level_q;
    wire       fallSeen   = ~pinLevel & level_q;
    // falling transitions when select is 1
    wire       validTrans = transSel ? fallSeen : riseSeen;
    reg        capture;
    wire [3:0] setupStatus;
    wire [3:0] holdStatus;

    // falling-edge pair; the pin meets no logic before its second flop
    always @(negedge clock) begin
        if (sys_rst) begin
            negSync1_q <= 1'b0;
            negSync2_q <= 1'b0;
        end else begin
            negSync1_q <= sysrefIn;
            negSync2_q <= negSync1_q;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            level_q <= 1'b0;
        end else begin
            sync1_q <= sysrefIn;
            sync2_q <= sync1_q;
            level_q <= pinLevel;
        end
    end

    // capture decision per mode
    always @* begin
        capture = 1'b0;
        case (mode)
            `MODE_CONTINUOUS: begin
                capture = validTrans;
            end
            `MODE_NSHOT: begin
                // one shot once the skip count is used up
                capture = validTrans && state_q == ST_ARMED && skipLeft_q == 4'h0;
            end
            default: begin
                capture = 1'b0;
            end
        endcase
    end

    // n-shot sequencer; writing n-shot mode to the control register re-arms
    always @(posedge clock) begin
        if (sys_rst) begin
            state_q    <= ST_IDLE;
            skipLeft_q <= 4'h0;
        end else if (ctrlWrite) begin
            if (newMode == `MODE_NSHOT) begin
                state_q    <= ST_ARMED;
                skipLeft_q <= ignoreCount_q;
            end else begin
                state_q <= ST_IDLE;
            end
        end else begin
            case (state_q)
                ST_ARMED: begin
                    if (validTrans && mode == `MODE_NSHOT) begin
                        if (skipLeft_q != 4'h0) begin
                            skipLeft_q <= skipLeft_q - 4'h1;
                        end else begin
                            state_q <= ST_DONE;
                        end
                    end
                end
                ST_DONE: begin
                    state_q <= ST_DONE;
                end
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // free-running divide-by-8 for the phase report
    always @(posedge clock) begin
        if (sys_rst) begin
            divider_q <= 3'h0;
        end else begin
            divider_q <= divider_q + 3'h1;
        end
    end

    always @(posedge clock) begin
        if (sys_rst) begin
            divPhase_q      <= 4'h0;
            eventCount_q    <= 8'h00;
            captureStrobe   <= 1'b0;
            timestampStrobe <= 1'b0;
            delayLine_q     <= 127'h0;
        end else begin
            captureStrobe <= capture;
            if (capture) begin
                // whole cycles in the top bits, half cycle from edge select
                divPhase_q <= {divider_q, edgeSel};
            end
            if (flagReset) begin
                eventCount_q <= 8'h00;
            end else if (capture) begin
                // 8-bit add wraps 255 to 0 by itself
                eventCount_q <= eventCount_q + 8'h01;
            end
            // one fixed register stage plus the programmed delay
            delayLine_q <= {delayLine_q[125:0], capture};
            if (tsDelay_q == 7'h00) begin
                timestampStrobe <= capture;
            end else begin
                timestampStrobe <= delayLine_q[tsDelay_q - 7'h01];
            end
        end
    end

    // register writes
    always @(posedge clock) begin
        if (sys_rst) begin
            control_q     <= `RST_CONTROL;
            ignoreCount_q <= `RST_IGNORE_COUNT;
            tsDelay_q     <= `RST_TS_DELAY;
        end else if (writeStrobe) begin
            case (address)
                `ADDR_SYSREF_CONTROL: begin
                    // reserved bits 7, 5 and 0 stay zero
                    control_q <= writeData & 8'h5e;
                end
                `ADDR_SYSREF_IGNORE_COUNT: begin
                    ignoreCount_q <= writeData[3:0];
                end
                `ADDR_SYSREF_TS_DELAY: begin
                    tsDelay_q <= writeData[6:0];
                end
                default: begin
                    control_q <= control_q;
                end
            endcase
        end
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clock) begin
        if (sys_rst) begin
            readData <= `RST_STATUS;
        end else if (readStrobe) begin
            case (address)
                `ADDR_SYSREF_CONTROL:      readData <= control_q;
                `ADDR_SYSREF_IGNORE_COUNT: readData <= {4'h0, ignoreCount_q};
                `ADDR_SYSREF_TS_DELAY:     readData <= {1'b0, tsDelay_q};
                `ADDR_SYSREF_SETUP_HOLD:   readData <= {holdStatus, setupStatus};
                `ADDR_SYSREF_DIV_PHASE:    readData <= {4'h0, divPhase_q};
                `ADDR_SYSREF_EVENT_COUNT:  readData <= eventCount_q;
                default:                   readData <= 8'h00;
            endcase
        end else begin
            readData <= 8'h00;
        end
    end

    sysref_window_monitor u_sysref_window_monitor (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .flagReset   (flagReset),
        .level       (pinLevel),
        .capture     (capture),
        .setupStatus (setupStatus),
        .holdStatus  (holdStatus)
    );
endmodule

/* tb/sysref_capture_monitor_asserts.sv */
// assertion checker for the sysref capture monitor ports
`timescale 1ns/1ps
module sysref_capture_monitor_asserts (
    input wire        clock,
    input wire        sys_rst,
    input wire        sysrefIn,
    input wire [11:0] address,
    input wire [7:0]  writeData,
    input wire        writeStrobe,
    input wire        readStrobe,
    input wire [7:0]  readData,
    input wire        captureStrobe,
    input wire        timestampStrobe
);
    logic [7:0] ctrl_q;
    logic [6:0] delay_q;
    // shadow copies, known only from writes seen at the port
    always @(posedge clock) begin
        if (sys_rst) begin
            ctrl_q  <= 8'h00;
            delay_q <= 7'h40;
        end else if (writeStrobe && address == 12'h120) begin
            ctrl_q <= writeData;
        end else if (writeStrobe && address == 12'h123) begin
            delay_q <= writeData[6:0];
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    sequence s_rd(a);
        readStrobe && address == a;
    endsequence
    property p_capPulse; captureStrobe |=> !captureStrobe; endproperty
    property p_quiet; $stable(sysrefIn) [*6] |-> !captureStrobe; endproperty
    property p_tsZero; captureStrobe && delay_q == 7'h00 |-> timestampStrobe; endproperty
    property p_tsTwo; captureStrobe && delay_q == 7'h02 |-> ##2 timestampStrobe; endproperty
    property p_tsDef; captureStrobe && delay_q == 7'h40 |-> ##64 timestampStrobe; endproperty
    property p_cntClr; ctrl_q[6] ##0 s_rd(12'h12a) |=> readData == 8'h00; endproperty
    property p_flagClr; ctrl_q[6] ##0 s_rd(12'h128) |=> readData == 8'h00; endproperty
    // mode 11 counts as disabled too
    property p_off;
        (ctrl_q[2:1] == 2'h0 || ctrl_q[2:1] == 2'h3) [*5] |-> !captureStrobe;
    endproperty
    property p_rdIdle; !readStrobe |=> readData == 8'h00; endproperty
    a_capPulse: assert property (p_capPulse) else $error("capture pulse too long");
    a_quiet: assert property (p_quiet) else $error("capture without pin change");
    a_tsZero: assert property (p_tsZero) else $error("timestamp delay 0 wrong");
    a_tsTwo: assert property (p_tsTwo) else $error("timestamp delay 2 wrong");
    a_tsDef: assert property (p_tsDef) else $error("timestamp delay 64 wrong");
    a_cntClr: assert property (p_cntClr) else $error("count not cleared");
    a_flagClr: assert property (p_flagClr) else $error("flags not cleared");
    a_off: assert property (p_off) else $error("capture while disabled");
    a_rdIdle: assert property (p_rdIdle) else $error("read data not idle");
endmodule

/* tb/sysref_source_model.sv */
// clock source model: drives the sysref strobe in whole pulses, low when idle
`timescale 1ns/1ps
module sysref_source_model (
    input  wire  clock,
    output logic sysrefOut
);
    initial sysrefOut = 1'b0;
    // each level held w cycles; w >= 2 or the two-flop sampler may miss it
    task automatic pulses(input int n, input int w);
        repeat (n) begin
            @(posedge clock);
            sysrefOut <= 1'b1;
            repeat (w) @(posedge clock);
            sysrefOut <= 1'b0;
            repeat (w - 1) @(posedge clock);
        end
        repeat (8) @(posedge clock);
    endtask
endmodule

/* tb/sysref_capture_monitor_tb.sv */
// self-checking bench for the sysref capture monitor
`timescale 1ns/1ps
module sysref_capture_monitor_tb;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic        sysrefIn;
    logic [11:0] address = 12'h000;
    logic [7:0]  writeData = 8'h00;
    logic        writeStrobe = 1'b0;
    logic        readStrobe = 1'b0;
    logic [7:0]  readData;
    logic        captureStrobe;
    logic        timestampStrobe;
    logic [7:0]  v;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          caps = 0;
    int          stamps = 0;
    int          base;
    always #5 clock = ~clock;
    sysref_capture_monitor u_sysref_capture_monitor (.clock, .sys_rst, .sysrefIn, .address,
        .writeData, .writeStrobe, .readStrobe, .readData, .captureStrobe, .timestampStrobe);
    sysref_source_model u_sysref_source_model (.clock, .sysrefOut(sysrefIn));
    always @(posedge clock) begin
        caps += captureStrobe;
        stamps += timestampStrobe;
    end
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t read %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic chkCnt(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            mismatches++;
            $display("BAD %0t count %0d want %0d", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        address <= a;
        writeData <= d;
        writeStrobe <= 1'b1;
        @(posedge clock);
        writeStrobe <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge clock);
        address <= a;
        readStrobe <= 1'b1;
        @(posedge clock);
        readStrobe <= 1'b0;
        #1 d = readData;
    endtask
    task automatic t_regs;
        rd(12'h121, v); chk(v, 8'h00);
        rd(12'h123, v); chk(v, 8'h40);
        rd(12'h128, v); chk(v, 8'h00);
        rd(12'h129, v); chk(v, 8'h00);
        rd(12'h12a, v); chk(v, 8'h00);
        wr(12'h121, 8'hff); rd(12'h121, v); chk(v, 8'h0f);
        wr(12'h123, 8'hff); rd(12'h123, v); chk(v, 8'h7f);
        wr(12'h128, 8'hff); rd(12'h128, v); chk(v, 8'h00);
        wr(12'h123, 8'h40);
        wr(12'h120, 8'h02);
        u_sysref_source_model.pulses(1, 3);
        repeat (70) @(posedge clock);
        #1 chkCnt(stamps, 1);
        rd(12'h128, v); chk(v, 8'hef);
        $display("registers and default delay done");
    endtask
    task automatic t_cont;
        wr(12'h123, 8'h00);
        base = caps;
        u_sysref_source_model.pulses(5, 3);
        chkCnt(caps - base, 5);
        rd(12'h12a, v); chk(v, 8'h06);
        rd(12'h128, v); chk(v, 8'he3);
        wr(12'h120, 8'h00);
        u_sysref_source_model.pulses(2, 3);
        chkCnt(caps - base, 5);
        wr(12'h120, 8'h0a);
        u_sysref_source_model.pulses(1, 3);
        rd(12'h129, v); chk(v & 8'hf1, 8'h01);
        wr(12'h120, 8'h00);
        wr(12'h123, 8'h02);
        wr(12'h120, 8'h12);
        u_sysref_source_model.pulses(2, 3);
        chkCnt(caps - base, 8);
        chkCnt(stamps, caps);
        $display("continuous capture done");
    endtask
    task automatic t_nshot(input int k);
        wr(12'h120, 8'h00);
        wr(12'h121, k[7:0]);
        base = caps;
        wr(12'h120, 8'h04);
        u_sysref_source_model.pulses(k, 3);
        chkCnt(caps - base, 0);
        u_sysref_source_model.pulses(3, 3);
        chkCnt(caps - base, 1);
        $display("single shot skip %0d done", k);
    endtask
    task automatic t_flag;
        wr(12'h120, 8'h42);
        rd(12'h12a, v); chk(v, 8'h00);
        rd(12'h128, v); chk(v, 8'h00);
        u_sysref_source_model.pulses(2, 3);
        rd(12'h12a, v); chk(v, 8'h00);
        rd(12'h128, v); chk(v, 8'h00);
        wr(12'h120, 8'h02);
        u_sysref_source_model.pulses(255, 3);
        rd(12'h12a, v); chk(v, 8'hff);
        u_sysref_source_model.pulses(1, 3);
        rd(12'h12a, v); chk(v, 8'h00);
        $display("flag reset and wrap done");
    endtask
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        t_regs;
        t_cont;
        t_nshot(0);
        t_nshot(1);
        t_nshot(15);
        t_flag;
        finish_test;
    end
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        finish_test;
    end
endmodule
bind sysref_capture_monitor sysref_capture_monitor_asserts u_sysref_capture_monitor_asserts (
    .clock, .sys_rst, .sysrefIn, .address, .writeData, .writeStrobe, .readStrobe,
    .readData, .captureStrobe, .timestampStrobe);
